// File: verilog/exception_vector_priority_arbiter.sv
`include "vec_arb_cfg.svh"

module exception_vector_priority_arbiter
  import vec_arb_pkg::*;
#(
  parameter int NUM_IRQ  = 32,
  parameter bit SECURITY = 1'b1
) (
  input  logic               clk_sys,
  input  logic               arst_n,
  input  logic               ce,
  input  logic [11:0]        address,
  input  logic               read,
  input  logic               write,
  input  logic [31:0]        writedata,
  input  logic               priv,
  output logic [31:0]        readdata,
  output logic               waitrequest,
  input  logic [31:0]        nonsecure_table_base_init,
  input  logic [31:0]        secure_table_base_init,
  input  logic               nonsecure_table_base_lock,
  input  logic               secure_table_ctrl_lock,
  input  logic [NUM_IRQ-1:0] irq_in,
  input  logic [15:0]        sys_pend_s,
  input  logic [15:0]        sys_pend_ns,
  input  rank_t              active_rank,
  input  logic               fetch_valid,
  input  logic [31:0]        fetch_word,
  output logic               sel_valid,
  output excnum_t            sel_excnum,
  output logic               sel_ns,
  output logic [31:0]        sel_vec_addr,
  output logic               take_req,
  output logic               handler_valid,
  output logic [31:0]        handler_addr,
  output logic               vector_fault,
  output logic [31:0]        reset_sp_addr,
  output logic [31:0]        reset_pc_addr
);

  localparam int NEXC      = `EXC_IRQ0 + NUM_IRQ;
  localparam int NTW       = (NUM_IRQ + 31) / 32;
  localparam int ALIGN_LOG = (NEXC <= `MIN_ALIGN_WORDS) ? $clog2(`MIN_ALIGN_WORDS)
                                                        : $clog2(NEXC);
  // Word alignment plus two byte bits are forced to zero in every base.
  localparam logic [31:0] BASE_MASK = ~((32'h1 << (ALIGN_LOG + 2)) - 32'h1);
  // Which system exception numbers exist in each bank, held as named constants for indexing.
  localparam logic [15:0] EXISTS_S  = `SYS_MASK_S;
  localparam logic [15:0] EXISTS_NS = `SYS_MASK_NS;

  typedef struct packed {
    load_state_t            ld;
    logic [1:0]             lock_m;
    logic [1:0]             lock_q;
    logic [31:0]            ns_init_m;
    logic [31:0]            ns_init_q;
    logic [31:0]            s_init_m;
    logic [31:0]            s_init_q;
    logic [NUM_IRQ-1:0]     irq_m;
    logic [NUM_IRQ-1:0]     irq_q;
    logic [31:0]            s_base;
    logic [31:0]            ns_base;
    logic                   demote;
    logic [2:0]             grp;
    logic [NTW*32-1:0]      tgt_ns;
    logic [NEXC-1:0][7:0]   prio;
    logic                   waitreq;
    logic [31:0]            rdata;
    logic                   sel_valid;
    excnum_t                sel_exc;
    logic                   sel_ns;
    rank_t                  sel_grp;
    logic [31:0]            sel_addr;
    logic                   take;
    logic                   h_valid;
    logic [31:0]            h_addr;
    logic                   vfault;
    logic [31:0]            rst_sp;
    logic [31:0]            rst_pc;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // Clears the bits below the table alignment.
  function automatic logic [31:0] align_base(input logic [31:0] b);
    return b & BASE_MASK;
  endfunction

  // Sort key {group rank, subpriority}; smaller is more urgent.
  function automatic logic [16:0] rank_of(input logic [7:0] p, input logic ns,
                                          input logic dem, input logic [2:0] g);
    logic [7:0] eff;
    logic [3:0] sh;
    // Demoted Non-secure priorities fold into the upper half of the range, 0x80 to 0xFF.
    eff = (ns && dem) ? (`DEMOTE_BASE | {1'b0, p[7:1]}) : p;
    sh  = {1'b0, g} + 4'h1;
    return {`RANK_CFG_BASE + {1'b0, eff >> sh}, eff & ~(8'hFF << sh)};
  endfunction

  // Next-state logic for the whole block.
  always_comb begin
    logic [16:0] best;
    logic [16:0] k;
    logic        hit;
    logic        ns_b;
    logic        pend;
    excnum_t     ex;
    logic [31:0] base;
    best = '1;
    k    = '0;
    hit  = 1'b0;
    ns_b = 1'b0;
    pend = 1'b0;
    ex   = '0;
    base = '0;
    s_nxt = s_r;

    // Pins from outside the clock domain pass two flip-flops first.
    s_nxt.lock_m    = {secure_table_ctrl_lock, nonsecure_table_base_lock};
    s_nxt.lock_q    = s_r.lock_m;
    s_nxt.ns_init_m = nonsecure_table_base_init;
    s_nxt.ns_init_q = s_r.ns_init_m;
    s_nxt.s_init_m  = secure_table_base_init;
    s_nxt.s_init_q  = s_r.s_init_m;
    s_nxt.irq_m     = irq_in;
    s_nxt.irq_q     = s_r.irq_m;

    // The init buses are straps: caught once the synchronisers have filled.
    unique case (s_r.ld)
      LD_W0: s_nxt.ld = LD_W1;
      LD_W1: s_nxt.ld = LD_W2;
      LD_W2: begin
        s_nxt.ld      = LD_DONE;
        s_nxt.ns_base = align_base(s_r.ns_init_q);
        s_nxt.s_base  = SECURITY ? align_base(s_r.s_init_q) : '0;
      end
      LD_DONE: s_nxt.ld = LD_DONE;
    endcase

    // Bus slave: one wait cycle, then a one-cycle answer. Held off until the
    // straps are loaded so that an early write cannot be overwritten.
    s_nxt.waitreq = 1'b1;
    if (s_r.ld == LD_DONE && (read || write)) begin
      if (s_r.waitreq) begin
        s_nxt.waitreq = 1'b0;
        s_nxt.rdata   = `RST_RDATA;
        if (address == `OFS_S_BASE) begin
          s_nxt.rdata = s_r.s_base;
        end else if (address == `OFS_NS_BASE) begin
          s_nxt.rdata = s_r.ns_base;
        end else if (address == `OFS_CTRL) begin
          s_nxt.rdata[`CTRL_DEMOTE_BIT]     = s_r.demote;
          s_nxt.rdata[`CTRL_GRP_LSB +: 3]   = s_r.grp;
        end else if (address == `OFS_STATUS) begin
          s_nxt.rdata[`STAT_EXC_LSB +: 9]   = s_r.sel_exc;
          s_nxt.rdata[`STAT_NS_BIT]         = s_r.sel_ns;
          s_nxt.rdata[`STAT_VALID_BIT]      = s_r.sel_valid;
          s_nxt.rdata[`STAT_TAKE_BIT]       = s_r.take;
        end
        for (int w = 0; w < NTW; w++) begin
          if (address == 12'(`OFS_TGT_NS + 4 * w)) begin
            s_nxt.rdata = s_r.tgt_ns[w*32 +: 32];
          end
        end
        for (int e = `EXC_FIRST_CFG; e < NEXC; e++) begin
          if (address == 12'(`OFS_PRIO + 4 * e)) begin
            s_nxt.rdata[7:0] = s_r.prio[e];
          end
        end
      end else if (write && priv) begin
        // Lock pins freeze the bases; other registers stay writable.
        if (address == `OFS_NS_BASE && !s_r.lock_q[0]) begin
          s_nxt.ns_base = align_base(writedata);
        end
        if (address == `OFS_S_BASE && !s_r.lock_q[1] && SECURITY) begin
          s_nxt.s_base = align_base(writedata);
        end
        if (address == `OFS_CTRL) begin
          s_nxt.demote = writedata[`CTRL_DEMOTE_BIT] && SECURITY;
          s_nxt.grp    = writedata[`CTRL_GRP_LSB +: 3];
        end
        for (int w = 0; w < NTW; w++) begin
          if (address == 12'(`OFS_TGT_NS + 4 * w)) begin
            s_nxt.tgt_ns[w*32 +: 32] = writedata;
          end
        end
        // NMI and hard fault have no priority register at all.
        for (int e = `EXC_FIRST_CFG; e < NEXC; e++) begin
          if (address == 12'(`OFS_PRIO + 4 * e)) begin
            s_nxt.prio[e] = writedata[7:0];
          end
        end
      end
    end

    // System exceptions in ascending number, Secure bank before Non-secure.
    // A strict compare keeps the earlier candidate on any full tie.
    for (int e = `EXC_NMI; e < `EXC_IRQ0; e++) begin
      for (int b = 0; b < 2; b++) begin
        if (b == 0) begin
          pend = sys_pend_s[e] && EXISTS_S[e];
        end else begin
          pend = sys_pend_ns[e] && EXISTS_NS[e] && SECURITY;
        end
        if (e == `EXC_NMI) begin
          k = {`RANK_NMI, 8'h00};
        end else if (e == `EXC_HARD) begin
          k = {`RANK_HARD, 8'h00};
        end else begin
          k = rank_of(s_r.prio[e], b[0], s_r.demote, s_r.grp);
        end
        if (pend && k < best) begin
          best = k;
          hit  = 1'b1;
          ex   = 9'(e);
          ns_b = b[0];
        end
      end
    end
    // Interrupts follow; their numbers are all above the system ones.
    for (int i = 0; i < NUM_IRQ; i++) begin
      k = rank_of(s_r.prio[`EXC_IRQ0 + i], s_r.tgt_ns[i] && SECURITY, s_r.demote, s_r.grp);
      if (s_r.irq_q[i] && k < best) begin
        best = k;
        hit  = 1'b1;
        ex   = 9'(`EXC_IRQ0 + i);
        ns_b = s_r.tgt_ns[i] && SECURITY;
      end
    end

    // Base is aligned, so the offset simply fills the low bits.
    base = (ns_b || !SECURITY) ? s_r.ns_base : s_r.s_base;
    s_nxt.sel_valid = hit;
    s_nxt.sel_exc   = ex;
    s_nxt.sel_ns    = ns_b;
    s_nxt.sel_grp   = best[16:8];
    s_nxt.sel_addr  = base | {21'h0, ex, 2'b00};
    // Only a strictly smaller group rank may preempt.
    s_nxt.take      = hit && (best[16:8] < active_rank);

    // Returned vector word: bit 0 marks compact code and is not part of the PC.
    s_nxt.h_valid = fetch_valid;
    if (fetch_valid) begin
      s_nxt.h_addr = {fetch_word[31:1], 1'b0};
      s_nxt.vfault = !fetch_word[0];
    end

    // Reset always fetches from the Secure table when security exists.
    s_nxt.rst_sp = (SECURITY ? s_r.s_base : s_r.ns_base) | `RESET_SP_OFS;
    s_nxt.rst_pc = (SECURITY ? s_r.s_base : s_r.ns_base) | `RESET_PC_OFS;
  end

  // All state registers; priorities reset to zero until programmed.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_r         <= '0;
      s_r.waitreq <= 1'b1;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign readdata      = s_r.rdata;
  assign waitrequest   = s_r.waitreq;
  assign sel_valid     = s_r.sel_valid;
  assign sel_excnum    = s_r.sel_exc;
  assign sel_ns        = s_r.sel_ns;
  assign sel_vec_addr  = s_r.sel_addr;
  assign take_req      = s_r.take;
  assign handler_valid = s_r.h_valid;
  assign handler_addr  = s_r.h_addr;
  assign vector_fault  = s_r.vfault;
  assign reset_sp_addr = s_r.rst_sp;
  assign reset_pc_addr = s_r.rst_pc;

  // All checks run on the system clock and rest while reset is held.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  chk_nmi_wins: assert property (ce && (sys_pend_s[2] || (SECURITY && sys_pend_ns[2])) |=>
    sel_valid && sel_excnum == `EXC_NMI) else $error("NMI not selected first");
  chk_ns_lock_held: assert property (ce && write && !waitrequest && priv &&
    address == `OFS_NS_BASE && s_r.lock_q[0] |=> $stable(s_r.ns_base))
    else $error("Locked Non-secure base changed");
  chk_s_lock_held: assert property (ce && write && !waitrequest && priv &&
    address == `OFS_S_BASE && s_r.lock_q[1] |=> $stable(s_r.s_base))
    else $error("Locked Secure base changed");
  chk_base_aligned: assert property (((s_r.ns_base | s_r.s_base) & ~BASE_MASK) == 32'h0)
    else $error("Table base below alignment");
  // The address was formed one edge ago, so it is held against the bases of that edge.
  chk_vec_addr: assert property (sel_valid && $past(ce) |-> sel_vec_addr ==
    (((sel_ns || !SECURITY) ? $past(s_r.ns_base) : $past(s_r.s_base)) |
     {21'h0, sel_excnum, 2'b00})) else $error("Vector address wrong table or offset");
  chk_vec_lsb: assert property (ce && fetch_valid |=> handler_valid &&
    vector_fault == !$past(fetch_word[0])) else $error("Vector bit 0 check wrong");
  chk_reset_secure: assert property (s_r.ld == LD_DONE && SECURITY ##1 ce |=>
    reset_pc_addr == ($past(s_r.s_base) | `RESET_PC_OFS)) else $error("Reset not Secure");
  chk_strict_preempt: assert property (ce ##1 take_req |->
    s_r.sel_grp < $past(active_rank)) else $error("Equal group preempted");
  chk_prio_reset: assert property (s_r.ld != LD_DONE |-> s_r.prio == '0)
    else $error("Priority not zero after reset");
  chk_bus_answer: assert property ((read || write) && waitrequest && s_r.ld == LD_DONE && ce
    |=> !waitrequest) else $error("Bus answer late");
  // A take request needs a selection strictly more urgent than the running rank.
  chk_take_rule: assert property (ce |=> take_req ==
    (sel_valid && s_r.sel_grp < $past(active_rank))) else $error("Take request wrong");
  // Hard fault outranks every configurable exception whenever no NMI competes.
  chk_hard_wins: assert property (ce && sys_pend_s[3] && !sys_pend_s[2] &&
    !(SECURITY && sys_pend_ns[2]) |=> sel_valid && sel_excnum == `EXC_HARD)
    else $error("Hard fault not above configurable");
  // The handler address drops only the code marker bit of the fetched word.
  chk_handler_addr: assert property (ce && fetch_valid |=>
    handler_addr == {$past(fetch_word[31:1]), 1'b0}) else $error("Handler address wrong");
  // The reset stack entry also comes from the Secure table.
  chk_reset_sp: assert property (s_r.ld == LD_DONE && SECURITY ##1 ce |=>
    reset_sp_addr == ($past(s_r.s_base) | `RESET_SP_OFS))
    else $error("Reset stack not Secure");
  // An unprivileged write must leave both table bases alone.
  chk_unpriv_write: assert property (ce && write && !waitrequest && !priv |=>
    $stable(s_r.ns_base) && $stable(s_r.s_base)) else $error("Unprivileged base write landed");

endmodule

// File: verilog/vec_arb_cfg.svh
`ifndef VEC_ARB_CFG_SVH
`define VEC_ARB_CFG_SVH

// Register byte offsets on the Avalon-MM slave.
`define OFS_S_BASE      12'h000
`define OFS_NS_BASE     12'h004
`define OFS_CTRL        12'h008
`define OFS_STATUS      12'h00C
`define OFS_TGT_NS      12'h040
`define OFS_PRIO        12'h400

// Field positions.
`define CTRL_DEMOTE_BIT 0
`define CTRL_GRP_LSB    8
`define STAT_EXC_LSB    0
`define STAT_NS_BIT     15
`define STAT_VALID_BIT  16
`define STAT_TAKE_BIT   31

// Reset values.
`define RST_PRIO        8'h00
`define RST_RDATA       32'h0000_0000

// Exception numbers and fixed ranks; configurable ranks start above the fixed ones.
`define EXC_NMI         9'h002
`define EXC_HARD        9'h003
`define EXC_FIRST_CFG   4
`define EXC_IRQ0        16
`define RANK_NMI        9'h002
`define RANK_HARD       9'h003
`define RANK_CFG_BASE   9'h004
`define DEMOTE_BASE     8'h80

// Exception numbers that exist per bank: 2..7, 11, 12, 14, 15 (7 is Secure only).
`define SYS_MASK_S      16'hD8FC
`define SYS_MASK_NS     16'hD87C

// Table layout.
`define MIN_ALIGN_WORDS 32
`define RESET_SP_OFS    32'h0000_0000
`define RESET_PC_OFS    32'h0000_0004

`endif

// File: verilog/vec_arb_pkg.sv
package vec_arb_pkg;

  typedef logic [8:0] excnum_t;
  typedef logic [8:0] rank_t;

  // Strap capture: two synchroniser edges, then the load edge.
  typedef enum logic [1:0] {
    LD_W0   = 2'b00,
    LD_W1   = 2'b01,
    LD_W2   = 2'b10,
    LD_DONE = 2'b11
  } load_state_t;

endpackage

// File: testbench/core_model.sv
// Stand-in for the processor core: it owns the execution rank and the vector fetch.
module core_model
  import vec_arb_pkg::*;
(
  input  logic        clk_sys,
  output rank_t       active_rank,
  output logic        fetch_valid,
  output logic [31:0] fetch_word
);
  timeunit 1ns;
  timeprecision 1ns;

  // Thread mode at start, so nothing is masked by the core.
  initial begin
    active_rank = 9'h1FF;
    fetch_valid = 1'b0;
    fetch_word  = 32'h0000_0000;
  end

  // Changes the running group rank right after an edge.
  task automatic set_rank(input rank_t r);
    @(posedge clk_sys);
    active_rank <= r;
  endtask

  // One-cycle fetch pulse; the word is scrambled afterwards so stale data never looks valid.
  task automatic fetch(input logic [31:0] w);
    @(posedge clk_sys);
    fetch_valid <= 1'b1;
    fetch_word  <= w;
    @(posedge clk_sys);
    fetch_valid <= 1'b0;
    fetch_word  <= ~w;
  endtask
endmodule

// File: testbench/exception_vector_priority_arbiter_bench.sv
`include "vec_arb_cfg.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module exception_vector_priority_arbiter_bench
  import vec_arb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys, arst_n, ce, read, write, priv, waitrequest;
  logic [11:0] address;
  logic [31:0] writedata, readdata, ns_init, s_init, handler_addr, sel_vec_addr;
  logic [31:0] reset_sp_addr, reset_pc_addr, fetch_word;
  logic        ns_lock, s_lock, fetch_valid, sel_valid, sel_ns, take_req;
  logic        handler_valid, vector_fault;
  logic [31:0] irq_in;
  logic [15:0] sys_pend_s, sys_pend_ns;
  rank_t       active_rank;
  excnum_t     sel_excnum;
  int          error_cnt = 0;
  int          cmp_count = 0;

  exception_vector_priority_arbiter #(.NUM_IRQ(32), .SECURITY(1'b1)) DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .priv(priv), .readdata(readdata),
    .waitrequest(waitrequest), .nonsecure_table_base_init(ns_init),
    .secure_table_base_init(s_init), .nonsecure_table_base_lock(ns_lock),
    .secure_table_ctrl_lock(s_lock), .irq_in(irq_in), .sys_pend_s(sys_pend_s),
    .sys_pend_ns(sys_pend_ns), .active_rank(active_rank), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .sel_valid(sel_valid), .sel_excnum(sel_excnum),
    .sel_ns(sel_ns), .sel_vec_addr(sel_vec_addr), .take_req(take_req),
    .handler_valid(handler_valid), .handler_addr(handler_addr),
    .vector_fault(vector_fault), .reset_sp_addr(reset_sp_addr),
    .reset_pc_addr(reset_pc_addr));

  core_model core (.clk_sys(clk_sys), .active_rank(active_rank),
                   .fetch_valid(fetch_valid), .fetch_word(fetch_word));

  // 10 MHz system clock.
  always #50 clk_sys = ~clk_sys;

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One Avalon transfer; the request is held until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    read      <= ~wr;
    write     <= wr;
    address   <= a;
    writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      $display("[FAIL] bus answer exp 0 got timeout");
      stop_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic chk_rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    `CHK(nm, e, q)
  endtask

  // Gives the synchronisers and the selection register time to follow the inputs.
  task automatic settle();
    repeat (5) @(posedge clk_sys);
  endtask

  task automatic chk_sel(input excnum_t n, input logic ns, input logic [31:0] va);
    `CHK("sel_valid", 1'b1, sel_valid)
    `CHK("sel_excnum", n, sel_excnum)
    `CHK("sel_ns", ns, sel_ns)
    `CHK("sel_vec_addr", va, sel_vec_addr)
  endtask

  // Waits for the handler pulse under a bound, then compares the handler outputs.
  task automatic chk_fetch(input logic [31:0] w, input logic flt);
    int n;
    n = 0;
    core.fetch(w);
    do begin
      @(posedge clk_sys);
      n++;
    end while (handler_valid !== 1'b1 && n < 10);
    `CHK("handler_addr", {w[31:1], 1'b0}, handler_addr)
    `CHK("vector_fault", flt, vector_fault)
    if (n >= 10) begin
      error_cnt++;
      $display("[FAIL] handler_valid exp 1 got timeout");
      stop_test();
    end
  endtask

  // Main sequence; the Secure strap carries low bits on purpose to see them aligned away.
  initial begin
    clk_sys = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    priv = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 12'h000;
    writedata = 32'h0000_0000;
    ns_init = 32'h2000_0000;
    s_init = 32'h1000_00FF;
    ns_lock = 1'b0;
    s_lock = 1'b0;
    irq_in = 32'h0000_0000;
    sys_pend_s = 16'h0000;
    sys_pend_ns = 16'h0000;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    chk_rd("s_base", `OFS_S_BASE, 32'h1000_0000);
    chk_rd("ns_base", `OFS_NS_BASE, 32'h2000_0000);
    `CHK("reset_sp", 32'h1000_0000, reset_sp_addr)
    `CHK("reset_pc", 32'h1000_0004, reset_pc_addr)
    chk_rd("prio_irq0", `OFS_PRIO + 12'h040, 32'h0000_0000);
    $display("test reset done");
    wr(`OFS_NS_BASE, 32'h0000_0000);
    chk_rd("ns_base", `OFS_NS_BASE, 32'h0000_0000);
    priv <= 1'b0;
    wr(`OFS_NS_BASE, 32'h4000_0000);
    priv <= 1'b1;
    ns_lock <= 1'b1;
    s_lock <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wr(`OFS_NS_BASE, 32'h4000_0000);
    wr(`OFS_S_BASE, 32'h5000_0000);
    chk_rd("ns_base", `OFS_NS_BASE, 32'h0000_0000);
    chk_rd("s_base", `OFS_S_BASE, 32'h1000_0000);
    ns_lock <= 1'b0;
    s_lock <= 1'b0;
    repeat (3) @(posedge clk_sys);
    wr(`OFS_NS_BASE, 32'h3000_0000);
    wr(`OFS_S_BASE, 32'h0800_0000);
    chk_rd("ns_base", `OFS_NS_BASE, 32'h3000_0000);
    chk_rd("s_base", `OFS_S_BASE, 32'h0800_0000);
    $display("test base done");
    sys_pend_s <= 16'h000C;
    irq_in <= 32'h0000_0001;
    core.set_rank(9'h004);
    settle();
    chk_sel(9'h002, 1'b0, 32'h0800_0008);
    `CHK("take_nmi", 1'b1, take_req)
    sys_pend_s <= 16'h0008;
    settle();
    chk_sel(9'h003, 1'b0, 32'h0800_000C);
    sys_pend_s <= 16'h0000;
    settle();
    chk_sel(9'h010, 1'b0, 32'h0800_0040);
    `CHK("take_equal", 1'b0, take_req)
    irq_in <= 32'h8000_0003;
    settle();
    chk_sel(9'h010, 1'b0, 32'h0800_0040);
    wr(`OFS_PRIO + 12'h040, 32'h0000_0040);
    settle();
    chk_sel(9'h011, 1'b0, 32'h0800_0044);
    wr(`OFS_PRIO + 12'h040, 32'h0000_0020);
    wr(`OFS_PRIO + 12'h044, 32'h0000_0021);
    wr(`OFS_PRIO + 12'h0BC, 32'h0000_0022);
    settle();
    chk_sel(9'h010, 1'b0, 32'h0800_0040);
    core.set_rank(9'h014);
    settle();
    `CHK("take_same_group", 1'b0, take_req)
    core.set_rank(9'h015);
    settle();
    `CHK("take_higher_group", 1'b1, take_req)
    wr(`OFS_PRIO + 12'h040, 32'h0000_00FF);
    wr(`OFS_PRIO + 12'h044, 32'h0000_00FF);
    settle();
    chk_sel(9'h02F, 1'b0, 32'h0800_00BC);
    $display("test priority done");
    irq_in <= 32'h0000_0003;
    wr(`OFS_PRIO + 12'h040, 32'h0000_0070);
    wr(`OFS_PRIO + 12'h044, 32'h0000_0000);
    wr(`OFS_TGT_NS, 32'h0000_0002);
    chk_rd("tgt_ns", `OFS_TGT_NS, 32'h0000_0002);
    settle();
    chk_sel(9'h011, 1'b1, 32'h3000_0044);
    wr(`OFS_CTRL, 32'h0000_0001);
    chk_rd("ctrl", `OFS_CTRL, 32'h0000_0001);
    settle();
    chk_sel(9'h010, 1'b0, 32'h0800_0040);
    wr(`OFS_CTRL, 32'h0000_0000);
    irq_in <= 32'h0000_0000;
    sys_pend_s[14] <= 1'b1;
    sys_pend_ns[14] <= 1'b1;
    settle();
    chk_sel(9'h00E, 1'b0, 32'h0800_0038);
    sys_pend_s <= 16'h0000;
    settle();
    chk_sel(9'h00E, 1'b1, 32'h3000_0038);
    chk_rd("status", `OFS_STATUS, 32'h8001_800E);
    ce <= 1'b0;
    sys_pend_ns <= 16'h0000;
    settle();
    chk_sel(9'h00E, 1'b1, 32'h3000_0038);
    ce <= 1'b1;
    settle();
    `CHK("idle_valid", 1'b0, sel_valid)
    $display("test security done");
    chk_fetch(32'h0000_1235, 1'b0);
    chk_fetch(32'h0000_1234, 1'b1);
    $display("test fetch done");
    stop_test();
  end
endmodule
